// >>> verilog/cotc_pkg.sv
// package: constants, types and helpers of the tuning control block
package cotc_pkg;

    // register offsets on the management interface
    localparam logic [15:0] ADDR_MIN_THZ   = 16'h818A;
    localparam logic [15:0] ADDR_MIN_FRAC  = 16'h818C;
    localparam logic [15:0] ADDR_TX_CH     = 16'hB400;
    localparam logic [15:0] ADDR_RX_CH     = 16'hB420;
    localparam logic [15:0] ADDR_TX_FT     = 16'hB430;
    localparam logic [15:0] ADDR_RX_FT     = 16'hB440;
    localparam logic [15:0] ADDR_MOD_FAULT_ALARM_WARNING_STATUS  = 16'hB01D;
    localparam logic [15:0] ADDR_RF_ERR    = 16'hBB55;
    localparam logic [15:0] ADDR_WL_STAT   = 16'hB1A0;
    localparam logic [15:0] ADDR_WL_LATCH  = 16'hB1D0;
    localparam logic [15:0] ADDR_WL_MASK   = 16'hB200;
    localparam logic [15:0] ADDR_READY     = 16'hB050;
    localparam logic [15:0] ADDR_CTRL      = 16'hB010;
    localparam logic [15:0] ADDR_CMD_ERR   = 16'hB00C;
    localparam logic [15:0] ADDR_TX_PEND   = 16'hBB0A;
    localparam logic [15:0] ADDR_RX_PEND   = 16'hB88F;

    // field positions
    localparam int BIT_READY    = 15;
    localparam int BIT_SOFT_DIS = 13;
    localparam int BIT_LOL      = 6;
    localparam int BIT_WL       = 14;
    localparam int BIT_PEND     = 0;
    localparam int BIT_NV_TX    = 0;
    localparam int BIT_NV_RX    = 1;
    localparam int LSB_RF_ERR   = 12;

    // serial management frame
    localparam logic [5:0] PREAMBLE_MIN = 6'h20;
    localparam logic [5:0] CNT_HDR      = 6'h0E;
    localparam logic [5:0] CNT_TA       = 6'h0F;
    localparam logic [5:0] CNT_DATA0    = 6'h10;
    localparam logic [5:0] CNT_END      = 6'h20;
    localparam logic [1:0] OP_ADDR      = 2'h0;
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [1:0] OP_READ_INC  = 2'h2;
    localparam logic [1:0] OP_READ      = 2'h3;
    localparam logic [4:0] PORT_ADDR    = 5'h00;
    localparam logic [4:0] DEV_ADDR     = 5'h01;

    // frequency arithmetic in MHz
    localparam logic [47:0] MHZ_PER_THZ  = 48'h0000000F4240;
    localparam logic [47:0] MHZ_PER_FRAC = 48'h000000000032;

    typedef enum logic [4:0] {
        ST_READY   = 5'b00001,
        ST_CLR_RDY = 5'b00010,
        ST_TX_OFF  = 5'b00100,
        ST_WAIT    = 5'b01000,
        ST_HOLD    = 5'b10000
    } cotc_state_t;

    typedef struct packed {
        logic [2:0] grid;
        logic [2:0] rsvd;
        logic [9:0] chan;
    } cotc_chan_t;

    typedef struct packed {
        logic [2:0] age;
        logic       rx_ft_done;
        logic       tx_ft_done;
        logic       tx_tune_done;
        logic       rx_lo_present;
        logic       rx_lof_fault;
        logic       tx_lof_fault;
        logic [3:0] rf_err;
        logic       mdio;
        logic       mdc;
    } cotc_pins_t;

    // grid code to spacing in MHz; unlisted codes give zero spacing
    function automatic logic [47:0] grid_mhz(input logic [2:0] code);
        case (code)
            3'h0:    grid_mhz = 48'h0000000186A0;
            3'h1:    grid_mhz = 48'h00000000C350;
            3'h2:    grid_mhz = 48'h0000000061A8;
            3'h3:    grid_mhz = 48'h0000000030D4;
            3'h4:    grid_mhz = 48'h00000000186A;
            default: grid_mhz = 48'h000000000000;
        endcase
    endfunction

    // channel 0 wraps below channel one; the host never programs it
    function automatic logic [47:0] freq_mhz(input cotc_chan_t c, input logic [15:0] thz,
                                             input logic [15:0] frac, input logic [15:0] ft);
        freq_mhz = ({38'h0, c.chan} - 48'h1) * grid_mhz(c.grid)
                 + {32'h0, thz} * MHZ_PER_THZ
                 + {32'h0, frac} * MHZ_PER_FRAC
                 + {{32{ft[15]}}, ft};
    endfunction

endpackage

// >>> verilog/cotc_top.sv
`timescale 1ns/1ps
// top: management register bank, serial slave and wavelength change sequencer
module cotc_top #(
    parameter int unsigned MODULE_CLASS = 1
) (
    input  logic        core_clk,
    input  logic        arst_n,
    input  logic        mdc,
    input  logic        mdio_i,
    output logic        mdio_o,
    output logic        mdio_oe,
    input  logic [3:0]  tx_rf_err,
    input  logic        tx_lof_fault,
    input  logic        rx_lof_fault,
    input  logic        rx_lo_present,
    input  logic        tx_tune_done,
    input  logic        tx_ft_done,
    input  logic        rx_ft_done,
    input  logic [2:0]  laser_age,
    input  logic [15:0] min_thz_in,
    input  logic [15:0] min_frac_in,
    output logic        transmit_disable,
    output logic        tx_tune_req,
    output logic        rx_tune_req,
    output logic        tx_ft_req,
    output logic        rx_ft_req,
    output logic [47:0] tx_freq_mhz,
    output logic [47:0] rx_freq_mhz,
    output logic        tx_host_lock_loss,
    output logic        wl_unlock_fault,
    output logic [2:0]  laser_bias_fault_alarm_warning_status
);

    cotc_pkg::cotc_pins_t  pin_s1_q;
    cotc_pkg::cotc_pins_t  pin_s2_q;
    cotc_pkg::cotc_pins_t  pin_raw;
    cotc_pkg::cotc_state_t st_q;
    cotc_pkg::cotc_chan_t  tx_ch_q;
    cotc_pkg::cotc_chan_t  rx_ch_q;
    logic [31:0] min_s1_q;
    logic [1:0]  ld_q;
    logic [15:0] min_thz_q;
    logic [15:0] min_frac_q;
    logic        mdc_prev_q;
    logic [5:0]  ones_q;
    logic        in_frame_q;
    logic [5:0]  cnt_q;
    logic [15:0] sh_q;
    logic [1:0]  op_q;
    logic        hit_q;
    logic [15:0] addr_q;
    logic [15:0] rd_sh_q;
    logic        wr_q;
    logic [15:0] wdata_q;
    logic        mdio_o_q;
    logic        mdio_oe_q;
    logic [2:0]  done_prev_q;
    logic        ready_q;
    logic        soft_dis_q;
    logic        tx_tune_req_q;
    logic        rx_tune_req_q;
    logic        tx_ft_req_q;
    logic        rx_ft_req_q;
    logic [15:0] tx_ft_q;
    logic [15:0] rx_ft_q;
    logic        tx_pend_q;
    logic        rx_pend_q;
    logic [1:0]  cmd_nv_q;
    logic        wl_latch_q;
    logic        wl_mask_q;
    logic [47:0] tx_freq_q;
    logic [47:0] rx_freq_q;
    logic        lol_q;
    logic        wl_fault_q;
    logic [2:0]  bias_q;

    // pin inputs, grouped so one synchroniser pair serves them all
    assign pin_raw = '{age: laser_age, rx_ft_done: rx_ft_done, tx_ft_done: tx_ft_done,
                       tx_tune_done: tx_tune_done, rx_lo_present: rx_lo_present,
                       rx_lof_fault: rx_lof_fault, tx_lof_fault: tx_lof_fault,
                       rf_err: tx_rf_err, mdio: mdio_i, mdc: mdc};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            min_s1_q <= 32'h00000000;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            min_s1_q <= {min_thz_in, min_frac_in};
        end
    end

    // start-up capture of the minimum frequency; nothing writes it later
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ld_q       <= 2'h0;
            min_thz_q  <= 16'h0000;
            min_frac_q <= 16'h0000;
        end else begin
            ld_q <= {ld_q[0], 1'b1};
            if (ld_q == 2'h1) begin
                min_thz_q  <= min_s1_q[31:16];
                min_frac_q <= min_s1_q[15:0];
            end
        end
    end

    // serial frame bit tracking
    wire        mdc_rise = pin_s2_q.mdc & ~mdc_prev_q;
    wire [15:0] sh_n     = {sh_q[14:0], pin_s2_q.mdio};
    wire [5:0]  cnt_n    = cnt_q + 6'h01;
    wire        rd_op    = op_q[1];
    wire        hdr_hit  = (sh_n[13:12] == 2'h0) && (sh_n[9:5] == cotc_pkg::PORT_ADDR)
                           && (sh_n[4:0] == cotc_pkg::DEV_ADDR);
    wire [15:0] rd_mux;

    // frame receiver; host sees read data one sync delay after each mdc rise
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdc_prev_q <= 1'b0;
            ones_q     <= 6'h00;
            in_frame_q <= 1'b0;
            cnt_q      <= 6'h00;
            sh_q       <= 16'h0000;
            op_q       <= 2'h0;
            hit_q      <= 1'b0;
            addr_q     <= 16'h0000;
            rd_sh_q    <= 16'h0000;
            wr_q       <= 1'b0;
            wdata_q    <= 16'h0000;
            mdio_o_q   <= 1'b0;
            mdio_oe_q  <= 1'b0;
        end else begin
            mdc_prev_q <= pin_s2_q.mdc;
            wr_q       <= 1'b0;
            if (mdc_rise && !in_frame_q) begin
                if (pin_s2_q.mdio) begin
                    ones_q <= (ones_q == 6'h3F) ? ones_q : ones_q + 6'h01;
                end else begin
                    ones_q     <= 6'h00;
                    in_frame_q <= (ones_q >= cotc_pkg::PREAMBLE_MIN);
                    cnt_q      <= 6'h01;
                    sh_q       <= 16'h0000;
                end
            end else if (mdc_rise) begin
                sh_q  <= sh_n;
                cnt_q <= cnt_n;
                if (cnt_n == cotc_pkg::CNT_HDR) begin
                    op_q  <= sh_n[11:10];
                    hit_q <= hdr_hit;
                end
                if (cnt_n == cotc_pkg::CNT_TA && hit_q && rd_op) begin
                    mdio_oe_q <= 1'b1;
                    mdio_o_q  <= 1'b0;
                    rd_sh_q   <= rd_mux;
                end
                if (cnt_n >= cotc_pkg::CNT_DATA0 && cnt_n < cotc_pkg::CNT_END && mdio_oe_q) begin
                    mdio_o_q <= rd_sh_q[15];
                    rd_sh_q  <= {rd_sh_q[14:0], 1'b0};
                end
                if (cnt_n == cotc_pkg::CNT_END) begin
                    in_frame_q <= 1'b0;
                    mdio_oe_q  <= 1'b0;
                    mdio_o_q   <= 1'b0;
                    if (hit_q && op_q == cotc_pkg::OP_ADDR) begin
                        addr_q <= sh_n;
                    end
                    if (hit_q && op_q == cotc_pkg::OP_READ_INC) begin
                        addr_q <= addr_q + 16'h0001;
                    end
                    wr_q    <= hit_q && (op_q == cotc_pkg::OP_WRITE);
                    wdata_q <= sh_n;
                end
            end
        end
    end

    // write decode
    wire we_txch  = wr_q & (addr_q == cotc_pkg::ADDR_TX_CH);
    wire we_rxch  = wr_q & (addr_q == cotc_pkg::ADDR_RX_CH);
    wire we_txft  = wr_q & (addr_q == cotc_pkg::ADDR_TX_FT);
    wire we_rxft  = wr_q & (addr_q == cotc_pkg::ADDR_RX_FT);
    wire we_ctrl  = wr_q & (addr_q == cotc_pkg::ADDR_CTRL);
    wire we_err   = wr_q & (addr_q == cotc_pkg::ADDR_CMD_ERR);
    wire we_latch = wr_q & (addr_q == cotc_pkg::ADDR_WL_LATCH);
    wire we_mask  = wr_q & (addr_q == cotc_pkg::ADDR_WL_MASK);

    // done strobes from the laser controller, edge detected
    wire [2:0] done_now  = {pin_s2_q.rx_ft_done, pin_s2_q.tx_ft_done, pin_s2_q.tx_tune_done};
    wire [2:0] done_rise = done_now & ~done_prev_q;

    // a transmit channel change is only taken from ready with the flag set
    wire tx_chg_go = we_txch & (st_q == cotc_pkg::ST_READY) & ready_q;
    wire host_dis  = wdata_q[cotc_pkg::BIT_SOFT_DIS];
    wire class3    = (MODULE_CLASS == 3);

    // wavelength change sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q          <= cotc_pkg::ST_READY;
            ready_q       <= 1'b1;
            soft_dis_q    <= 1'b0;
            tx_tune_req_q <= 1'b0;
        end else begin
            tx_tune_req_q <= 1'b0;
            case (st_q)
                cotc_pkg::ST_READY: begin
                    if (tx_chg_go) begin
                        st_q <= cotc_pkg::ST_CLR_RDY;
                    end else if (we_ctrl) begin
                        soft_dis_q <= host_dis;
                    end
                end
                cotc_pkg::ST_CLR_RDY: begin
                    ready_q <= 1'b0;
                    st_q    <= cotc_pkg::ST_TX_OFF;
                end
                cotc_pkg::ST_TX_OFF: begin
                    soft_dis_q    <= 1'b1;
                    tx_tune_req_q <= 1'b1;
                    st_q          <= cotc_pkg::ST_WAIT;
                end
                cotc_pkg::ST_WAIT: begin
                    // host disable writes are dropped here, the sequence owns the bit
                    if (done_rise[0]) begin
                        ready_q <= 1'b1;
                        st_q    <= cotc_pkg::ST_HOLD;
                    end
                end
                cotc_pkg::ST_HOLD: begin
                    if (!class3) begin
                        soft_dis_q <= 1'b0;
                        st_q       <= cotc_pkg::ST_READY;
                    end else if (we_ctrl && !host_dis) begin
                        soft_dis_q <= 1'b0;
                        st_q       <= cotc_pkg::ST_READY;
                    end
                end
                default: begin
                    st_q <= cotc_pkg::ST_READY;
                end
            endcase
        end
    end

    // fine tune: never gates the ready flag, a busy laser rejects the write
    wire tx_ft_go  = we_txft & ~tx_pend_q;
    wire rx_ft_go  = we_rxft & ~rx_pend_q;
    wire [1:0] nv_set = {we_rxft & rx_pend_q, we_txft & tx_pend_q};
    wire [1:0] nv_clr = we_err ? wdata_q[1:0] : 2'h0;
    wire rx_ch_go  = we_rxch & ready_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_prev_q   <= 3'h0;
            tx_ch_q       <= '0;
            rx_ch_q       <= '0;
            tx_ft_q       <= 16'h0000;
            rx_ft_q       <= 16'h0000;
            tx_pend_q     <= 1'b0;
            rx_pend_q     <= 1'b0;
            cmd_nv_q      <= 2'h0;
            tx_ft_req_q   <= 1'b0;
            rx_ft_req_q   <= 1'b0;
            rx_tune_req_q <= 1'b0;
        end else begin
            done_prev_q   <= done_now;
            tx_ft_req_q   <= tx_ft_go;
            rx_ft_req_q   <= rx_ft_go;
            rx_tune_req_q <= rx_ch_go;
            tx_pend_q     <= tx_ft_go | (tx_pend_q & ~done_rise[1]);
            rx_pend_q     <= rx_ft_go | (rx_pend_q & ~done_rise[2]);
            cmd_nv_q      <= nv_set | (cmd_nv_q & ~nv_clr);
            if (tx_chg_go) begin
                tx_ch_q <= wdata_q;
            end
            if (rx_ch_go) begin
                rx_ch_q <= wdata_q;
            end
            if (tx_ft_go) begin
                tx_ft_q <= wdata_q;
            end
            if (rx_ft_go) begin
                rx_ft_q <= wdata_q;
            end
        end
    end

    // status mapping and frequency results, all registered
    wire wl_fault_now = pin_s2_q.tx_lof_fault | (pin_s2_q.rx_lo_present & pin_s2_q.rx_lof_fault);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wl_latch_q <= 1'b0;
            wl_mask_q  <= 1'b0;
            wl_fault_q <= 1'b0;
            lol_q      <= 1'b0;
            bias_q     <= 3'h0;
            tx_freq_q  <= 48'h000000000000;
            rx_freq_q  <= 48'h000000000000;
        end else begin
            wl_fault_q <= wl_fault_now;
            // a fault in the clearing cycle keeps the latch set
            wl_latch_q <= wl_fault_now | (wl_latch_q & ~(we_latch & wdata_q[cotc_pkg::BIT_WL]));
            if (we_mask) begin
                wl_mask_q <= wdata_q[cotc_pkg::BIT_WL];
            end
            lol_q     <= |pin_s2_q.rf_err;
            bias_q    <= pin_s2_q.age;
            tx_freq_q <= cotc_pkg::freq_mhz(tx_ch_q, min_thz_q, min_frac_q, tx_ft_q);
            rx_freq_q <= cotc_pkg::freq_mhz(rx_ch_q, min_thz_q, min_frac_q, rx_ft_q);
        end
    end

    // read selection; unmapped offsets read zero
    wire [15:0] rf_reg   = {pin_s2_q.rf_err, 12'h000};
    wire [15:0] fault_alarm_warning_status_reg = {15'h0000, lol_q} << cotc_pkg::BIT_LOL;
    wire [15:0] stat_reg = {15'h0000, wl_fault_q} << cotc_pkg::BIT_WL;
    wire [15:0] lat_reg  = {15'h0000, wl_latch_q} << cotc_pkg::BIT_WL;
    wire [15:0] msk_reg  = {15'h0000, wl_mask_q} << cotc_pkg::BIT_WL;
    wire [15:0] rdy_reg  = {15'h0000, ready_q} << cotc_pkg::BIT_READY;
    wire [15:0] ctl_reg  = {15'h0000, soft_dis_q} << cotc_pkg::BIT_SOFT_DIS;
    wire [15:0] txp_reg  = {15'h0000, tx_pend_q} << cotc_pkg::BIT_PEND;
    wire [15:0] rxp_reg  = {15'h0000, rx_pend_q} << cotc_pkg::BIT_PEND;

    assign rd_mux = (addr_q == cotc_pkg::ADDR_MIN_THZ)  ? min_thz_q  :
                    (addr_q == cotc_pkg::ADDR_MIN_FRAC) ? min_frac_q :
                    (addr_q == cotc_pkg::ADDR_TX_CH)    ? tx_ch_q    :
                    (addr_q == cotc_pkg::ADDR_RX_CH)    ? rx_ch_q    :
                    (addr_q == cotc_pkg::ADDR_TX_FT)    ? tx_ft_q    :
                    (addr_q == cotc_pkg::ADDR_RX_FT)    ? rx_ft_q    :
                    (addr_q == cotc_pkg::ADDR_MOD_FAULT_ALARM_WARNING_STATUS) ? fault_alarm_warning_status_reg   :
                    (addr_q == cotc_pkg::ADDR_RF_ERR)   ? rf_reg     :
                    (addr_q == cotc_pkg::ADDR_WL_STAT)  ? stat_reg   :
                    (addr_q == cotc_pkg::ADDR_WL_LATCH) ? lat_reg    :
                    (addr_q == cotc_pkg::ADDR_WL_MASK)  ? msk_reg    :
                    (addr_q == cotc_pkg::ADDR_READY)    ? rdy_reg    :
                    (addr_q == cotc_pkg::ADDR_CTRL)     ? ctl_reg    :
                    (addr_q == cotc_pkg::ADDR_CMD_ERR)  ? {14'h0000, cmd_nv_q} :
                    (addr_q == cotc_pkg::ADDR_TX_PEND)  ? txp_reg    :
                    (addr_q == cotc_pkg::ADDR_RX_PEND)  ? rxp_reg    : 16'h0000;

    // outputs straight from flops
    assign mdio_o            = mdio_o_q;
    assign mdio_oe           = mdio_oe_q;
    assign transmit_disable  = soft_dis_q;
    assign tx_tune_req       = tx_tune_req_q;
    assign rx_tune_req       = rx_tune_req_q;
    assign tx_ft_req         = tx_ft_req_q;
    assign rx_ft_req         = rx_ft_req_q;
    assign tx_freq_mhz       = tx_freq_q;
    assign rx_freq_mhz       = rx_freq_q;
    assign tx_host_lock_loss = lol_q;
    assign wl_unlock_fault   = wl_fault_q;
    assign laser_bias_fault_alarm_warning_status   = bias_q;

endmodule

// >>> verif/cotc_chk.sv
// checker: port-level timing relations of the tuning control block
`timescale 1ns/1ps
module cotc_chk #(
    parameter int unsigned MODULE_CLASS = 1
) (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic [3:0] tx_rf_err,
    input wire logic       tx_lof_fault,
    input wire logic       rx_lof_fault,
    input wire logic       rx_lo_present,
    input wire logic       tx_tune_done,
    input wire logic [2:0] laser_age,
    input wire logic       transmit_disable,
    input wire logic       tx_tune_req,
    input wire logic       rx_tune_req,
    input wire logic       tx_ft_req,
    input wire logic       rx_ft_req,
    input wire logic       tx_host_lock_loss,
    input wire logic       wl_unlock_fault,
    input wire logic [2:0] laser_bias_fault_alarm_warning_status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // six stable cycles cover the two-flop sync plus the output register
    lock_loss_or_a: assert property ($stable(tx_rf_err) [*6] |-> tx_host_lock_loss == |tx_rf_err)
        else $error("lock loss not or of rf errors");
    wl_unlock_map_a: assert property ($stable({tx_lof_fault, rx_lof_fault, rx_lo_present}) [*6]
        |-> wl_unlock_fault == (tx_lof_fault | (rx_lo_present & rx_lof_fault))) else $error("unlock fault wrong");
    age_mirror_a: assert property ($stable(laser_age) [*6] |-> laser_bias_fault_alarm_warning_status == laser_age)
        else $error("aging not mirrored");
    tune_disables_a: assert property (tx_tune_req |-> ##[0:1] transmit_disable)
        else $error("change started with output on");
    tune_once_a: assert property (tx_tune_req |=> !tx_tune_req [*8])
        else $error("change request repeated");
    auto_reenable_a: assert property (MODULE_CLASS != 3 && $rose(tx_tune_done) |-> ##[1:10] !transmit_disable)
        else $error("output not restored");
    ft_keeps_on_a: assert property ((tx_ft_req | rx_ft_req | rx_tune_req) && !transmit_disable
        |=> !transmit_disable [*8]) else $error("fine tune turned output off");
    ft_pulse_a: assert property ((tx_ft_req | rx_ft_req) |=> !(tx_ft_req | rx_ft_req))
        else $error("fine tune request not a pulse");
    cover property (tx_tune_req);
    cover property ($fell(transmit_disable));
    cover property (tx_ft_req);
endmodule
bind cotc_top cotc_chk #(.MODULE_CLASS(MODULE_CLASS)) cotc_chk_inst (.core_clk, .arst_n, .tx_rf_err,
    .tx_lof_fault, .rx_lof_fault, .rx_lo_present, .tx_tune_done, .laser_age, .transmit_disable, .tx_tune_req,
    .rx_tune_req, .tx_ft_req, .rx_ft_req, .tx_host_lock_loss, .wl_unlock_fault, .laser_bias_fault_alarm_warning_status);

// >>> verif/cotc_host.sv
// host model: management frames on mdc and the shared data line
`timescale 1ns/1ps
module cotc_host (
    input  wire logic core_clk,
    input  wire logic mdio_o,
    input  wire logic mdio_oe,
    output logic      mdc,
    output logic      mdio_i
);
    logic        drv_q;
    logic        bit_q;
    logic [15:0] rd_q;
    // a line nobody drives is pulled high
    assign mdio_i = mdio_oe ? mdio_o : (drv_q ? bit_q : 1'b1);
    initial begin
        mdc = 1'b1;
        drv_q = 1'b0;
        bit_q = 1'b1;
        rd_q = 16'h0000;
    end
    // data changes with mdc low so the slave samples a settled level
    task automatic xfer(input logic [1:0] op, input logic [15:0] d);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h0, op, cotc_pkg::PORT_ADDR, cotc_pkg::DEV_ADDR, 2'h2, d};
        for (int i = 63; i >= 0; i--) begin
            mdc <= 1'b0;
            drv_q <= !(op[1] && i < 18);
            bit_q <= f[i];
            repeat (4) @(posedge core_clk);
            mdc <= 1'b1;
            rd_q <= {rd_q[14:0], mdio_i};
            repeat (4) @(posedge core_clk);
        end
        drv_q <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule

// >>> verif/tb_top.sv
// bench: tuning control block driven through the host model
`timescale 1ns/1ps
module tb_top;
    logic        core_clk, arst_n, mdc, mdio_i, mdio_o, mdio_oe, tx_lof_fault, rx_lof_fault;
    logic        rx_lo_present, tx_tune_done, tx_ft_done, rx_ft_done, transmit_disable, tx_tune_req;
    logic        rx_tune_req, tx_ft_req, rx_ft_req, tx_host_lock_loss, wl_unlock_fault;
    logic [3:0]  tx_rf_err;
    logic [2:0]  laser_age, laser_bias_fault_alarm_warning_status;
    logic [15:0] min_thz_in, min_frac_in, rd;
    logic [47:0] tx_freq_mhz, rx_freq_mhz;
    int          err_count, checked;
    cotc_top cotc_top_inst (.core_clk, .arst_n, .mdc, .mdio_i, .mdio_o, .mdio_oe, .tx_rf_err, .tx_lof_fault,
        .rx_lof_fault, .rx_lo_present, .tx_tune_done, .tx_ft_done, .rx_ft_done, .laser_age, .min_thz_in,
        .min_frac_in, .transmit_disable, .tx_tune_req, .rx_tune_req, .tx_ft_req, .rx_ft_req, .tx_freq_mhz,
        .rx_freq_mhz, .tx_host_lock_loss, .wl_unlock_fault, .laser_bias_fault_alarm_warning_status);
    cotc_host cotc_host_inst (.core_clk, .mdc, .mdio_i, .mdio_o, .mdio_oe);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s: %0h vs %0h", $time, msg, seen, exp);
        end
    endtask
    // expected MHz: channel one is 191 THz plus 20 x 50 MHz from the straps
    function automatic logic [47:0] f_exp(input logic [47:0] n, input logic [47:0] g, input logic [15:0] ft);
        f_exp = (n - 48'h1) * g + 48'hBF * 48'hF4240 + 48'h14 * 48'h32 + {{32{ft[15]}}, ft};
    endfunction
    // settle time lets the write pass the synchronisers and sequencer
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        cotc_host_inst.xfer(cotc_pkg::OP_ADDR, a);
        cotc_host_inst.xfer(cotc_pkg::OP_WRITE, d);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic rdr(input logic [15:0] a);
        cotc_host_inst.xfer(cotc_pkg::OP_ADDR, a);
        cotc_host_inst.xfer(cotc_pkg::OP_READ, 16'h0000);
        rd = cotc_host_inst.rd_q;
    endtask
    task automatic t_fault_alarm_warning_status();
        for (int i = 0; i < 4; i++) begin
            tx_rf_err <= 4'h1 << i;
            repeat (6) @(posedge core_clk);
            chk(tx_host_lock_loss, 1'b1, "lock loss");
        end
        tx_rf_err <= 4'hA;
        rdr(cotc_pkg::ADDR_RF_ERR);
        chk(rd[15:12], 4'hA, "rf err");
        rdr(cotc_pkg::ADDR_MOD_FAULT_ALARM_WARNING_STATUS);
        chk(rd[cotc_pkg::BIT_LOL], 1'b1, "lol bit");
        tx_rf_err <= 4'h0;
        tx_lof_fault <= 1'b1;
        laser_age <= 3'h5;
        repeat (6) @(posedge core_clk);
        chk(tx_host_lock_loss, 1'b0, "lock clear");
        chk(laser_bias_fault_alarm_warning_status, 3'h5, "aging");
        rdr(cotc_pkg::ADDR_WL_STAT);
        chk(rd[cotc_pkg::BIT_WL], 1'b1, "unlock bit");
        rdr(cotc_pkg::ADDR_WL_LATCH);
        chk(rd[cotc_pkg::BIT_WL], 1'b1, "unlock latch");
        wr(cotc_pkg::ADDR_WL_MASK, 16'h4000);
        rdr(cotc_pkg::ADDR_WL_MASK);
        chk(rd[cotc_pkg::BIT_WL], 1'b1, "unlock mask");
        // fault still present, so the clear must lose to the set
        wr(cotc_pkg::ADDR_WL_LATCH, 16'h4000);
        rdr(cotc_pkg::ADDR_WL_LATCH);
        chk(rd[cotc_pkg::BIT_WL], 1'b1, "latch holds");
        tx_lof_fault <= 1'b0;
        rx_lof_fault <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(wl_unlock_fault, 1'b0, "no rx laser");
        rx_lo_present <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(wl_unlock_fault, 1'b1, "rx laser fault");
        rx_lof_fault <= 1'b0;
        wr(cotc_pkg::ADDR_WL_LATCH, 16'h4000);
        rdr(cotc_pkg::ADDR_WL_LATCH);
        chk(rd[cotc_pkg::BIT_WL], 1'b0, "latch clear");
        $display("test fault_alarm_warning_status done");
    endtask
    task automatic t_change();
        wr(cotc_pkg::ADDR_TX_CH, 16'h2003);
        chk(transmit_disable, 1'b1, "output off");
        wr(cotc_pkg::ADDR_TX_CH, 16'h2001);
        // output is off here, yet the start-up frequency register has no write decode and ignores this write
        wr(cotc_pkg::ADDR_MIN_THZ, 16'h1234);
        rdr(cotc_pkg::ADDR_READY);
        chk(rd[cotc_pkg::BIT_READY], 1'b0, "busy");
        tx_tune_done <= 1'b1;
        repeat (10) @(posedge core_clk);
        tx_tune_done <= 1'b0;
        chk(transmit_disable, 1'b0, "output on");
        chk(tx_freq_mhz, f_exp(48'h3, 48'hC350, 16'h0000), "tx freq");
        rdr(cotc_pkg::ADDR_READY);
        chk(rd[cotc_pkg::BIT_READY], 1'b1, "ready");
        $display("test change done");
    endtask
    task automatic t_fine();
        wr(cotc_pkg::ADDR_TX_FT, 16'h0064);
        chk(transmit_disable, 1'b0, "on in fine");
        rdr(cotc_pkg::ADDR_TX_PEND);
        chk(rd[cotc_pkg::BIT_PEND], 1'b1, "pending");
        wr(cotc_pkg::ADDR_TX_FT, 16'h0001);
        rdr(cotc_pkg::ADDR_CMD_ERR);
        chk(rd[1:0], 2'h1, "not valid");
        wr(cotc_pkg::ADDR_CMD_ERR, 16'h0001);
        rdr(cotc_pkg::ADDR_CMD_ERR);
        chk(rd[1:0], 2'h0, "nv clear");
        rdr(cotc_pkg::ADDR_READY);
        chk(rd[cotc_pkg::BIT_READY], 1'b1, "ready fine");
        chk(tx_freq_mhz, f_exp(48'h3, 48'hC350, 16'h0064), "tx fine");
        tx_ft_done <= 1'b1;
        rx_ft_done <= 1'b1;
        rdr(cotc_pkg::ADDR_TX_PEND);
        chk(rd[cotc_pkg::BIT_PEND], 1'b0, "pend clear");
        wr(cotc_pkg::ADDR_RX_CH, 16'h0002);
        wr(cotc_pkg::ADDR_RX_FT, 16'hFF9C);
        chk(transmit_disable, 1'b0, "on in rx");
        chk(rx_freq_mhz, f_exp(48'h2, 48'h186A0, 16'hFF9C), "rx freq");
        rdr(cotc_pkg::ADDR_MIN_THZ);
        chk(rd, 16'h00BF, "min thz");
        rdr(16'h8000);
        chk(rd, 16'h0000, "unmapped");
        $display("test fine done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {arst_n, tx_lof_fault, rx_lof_fault, rx_lo_present, tx_tune_done, tx_ft_done, rx_ft_done} = 7'h00;
        tx_rf_err = 4'h0;
        laser_age = 3'h0;
        min_thz_in = 16'h00BF;
        min_frac_in = 16'h0014;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_fault_alarm_warning_status();
        t_change();
        t_fine();
        wrap_up();
    end
    // far beyond the roughly 30k cycles the frames need
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end
endmodule
